// file: bli_pkg.sv
`default_nettype none
package bli_pkg;
  // Target address choice made by the mode strap
  localparam logic [6:0] ADDR_PRIMARY   = 7'h2a;
  localparam logic [6:0] ADDR_ALTERNATE = 7'h2b;
  // Register offsets
  localparam logic [7:0] OFF_BRIGHTNESS    = 8'h00;
  localparam logic [7:0] OFF_SINK_CURRENT  = 8'h02;
  localparam logic [7:0] OFF_GENERAL_A     = 8'h04;
  localparam logic [7:0] OFF_GENERAL_B     = 8'h06;
  localparam logic [7:0] OFF_SUPPLY_EN     = 8'h08;
  localparam logic [7:0] OFF_BOOST_EN      = 8'h0a;
  localparam logic [7:0] OFF_STRING_EN     = 8'h0c;
  localparam logic [7:0] OFF_SUPPLY_FLAGS  = 8'h0e;
  localparam logic [7:0] OFF_BOOST_FLAGS   = 8'h10;
  localparam logic [7:0] OFF_STRING_FLAGS  = 8'h12;
  localparam logic [7:0] OFF_STATE_RD      = 8'h14;
  localparam logic [7:0] OFF_IN_DUTY_RD    = 8'h16;
  localparam logic [7:0] OFF_OUT_DUTY_RD   = 8'h18;
  localparam logic [7:0] OFF_SINK_DAC_RD   = 8'h1a;
  localparam logic [7:0] OFF_BOOST_TGT_RD  = 8'h1c;
  localparam logic [7:0] OFF_STRAP_RD      = 8'h1e;
  localparam logic [7:0] OFF_LAST          = 8'h1e;
  // Reset values
  localparam logic [15:0] RST_BRIGHTNESS   = 16'h0000;
  localparam logic [15:0] RST_SINK_CURRENT = 16'h0fff;
  localparam logic [15:0] RST_GENERAL_A    = 16'h08a3;
  localparam logic [15:0] RST_GENERAL_B    = 16'h0000;
  localparam logic [7:0]  RST_ALERT_EN     = 8'hff;
  // Field positions in general_settings_a
  localparam int GA_PSEUDO_POS = 14;
  localparam int GA_RATE_POS   = 12;
  localparam int GA_RANGE_POS  = 10;
  localparam int GA_SRC_POS    = 8;
  localparam int GA_RAMP_POS   = 5;
  localparam int GA_DITHER_POS = 2;
  localparam int GA_SMOOTH_POS = 1;
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_REG = 2'h2;
  localparam logic [2:0] MAX_DITHER = 3'h3;
  // Alert enable field codes
  localparam logic [1:0] ALERT_DISABLE = 2'b01;
  localparam logic [1:0] ALERT_ENABLE  = 2'b11;
  // Fault slot assignment inside the supply group
  localparam int GLOBAL_ALERT_IDX = 7;
  localparam int TIMEOUT_FAULT_IDX = 6;
  localparam int FAULTS_PER_GROUP = 8;
  localparam int FAULT_GROUPS = 3;
  // Timing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_MHZ = 250;
  localparam int BUS_TIMEOUT_MS = 500;
  localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_MS * CLK_MHZ * 1000;
  localparam logic [2:0] STRAP_SETTLE_CYCLES = 3'h4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_ACK_ADDR = 4'h2, ST_REG = 4'h3,
    ST_ACK_REG = 4'h4, ST_WDATA = 4'h5, ST_ACK_WDATA = 4'h6,
    ST_RDATA = 4'h7, ST_RD_ACK = 4'h8, ST_IGNORE = 4'h9
  } bli_i2c_e;

  typedef struct packed {
    logic [7:0] supply;
    logic [7:0] boost;
    logic [7:0] strng;
  } bli_faults_s;

  typedef struct packed {
    logic [7:0]  liveStateField;
    logic [15:0] inputDuty;
    logic [15:0] outputDutyField;
    logic [11:0] sinkDacField;
    logic [9:0]  boostTargetField;
  } bli_diag_s;

  typedef struct packed {
    logic [15:0] brightnessWord;
    logic [11:0] sinkCurrent;
    logic [1:0]  spreadRange;
    logic [1:0]  spreadRateSel;
    logic        spreadPseudoEn;
    logic [2:0]  rampSel;
    logic        smoothRampEn;
    logic [2:0]  ditherBits;
    logic [15:0] generalB;
  } bli_cfg_s;
endpackage
`default_nettype wire

// file: bli_regbank.sv
// What this block does
// - Answer on target address 0x2A or 0x2B
// - Write: address, register byte, two data
// - Read: address, register, repeated start, two bytes
// - Configuration writable in every device state
// - Enabled fault asserts alert, flags readable
// - Clear flag only when status+clear written
// - Two-bit enable, reads 2b10 when enabled
// - Write 01 disables, 11 enables alert
// - Global enable off blocks every alert
// - Readout of functional state machine state
// - Readout of measured input duty cycle
// - Readout of LED output duty cycle
// - Readout of 12-bit sink DAC code
// - Readout of 10-bit boost voltage target
// - Readout of four strap detection results
// - Brightness from input pin or register
// - Dither up to three bits
// - Smooth ramp enable and ramp duration
// - Spread range, rate and pseudo-random enable
// - No STOP in 500ms sets timeout flag
// - Bad mode strap: phase-shift, address 0x2A
// - Source code 0 pin, 2 register, others reserved
`default_nettype none
module bli_regbank
  import bli_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output var  logic        sdaOut,
  output var  logic        sdaOe,
  input  wire logic [2:0]  modeStrap,
  input  wire logic [3:0]  stringStrap,
  input  wire logic [3:0]  boostFreqStrap,
  input  wire logic [3:0]  dimFreqStrap,
  input  wire bli_faults_s faultIn,
  input  wire bli_diag_s   diagIn,
  output var  bli_cfg_s    cfgOut,
  output var  logic [15:0] effBrightness,
  output var  logic        alertOut,
  output var  logic        alertOe
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TW-1:0] TIMEOUT_LAST = TW'(TIMEOUT_CYCLES - 1);

  generate
    if (TIMEOUT_CYCLES < 16) begin : g_bad_timeout
      $error("TIMEOUT_CYCLES must be at least 16");
    end
  endgenerate

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a <= OFF_LAST) && !a[0];
  endfunction

  // Pin synchronisers; stage 1 feeds stage 2 only
  logic sclS1_reg, sclS2_reg, sclS3_reg;
  logic sdaS1_reg, sdaS2_reg, sdaS3_reg;
  logic [14:0] strapS1_reg, strapS2_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {sclS1_reg, sclS2_reg, sclS3_reg} <= 3'h7;
      {sdaS1_reg, sdaS2_reg, sdaS3_reg} <= 3'h7;
    end else begin
      {sclS1_reg, sclS2_reg, sclS3_reg} <= {sclIn, sclS1_reg, sclS2_reg};
      {sdaS1_reg, sdaS2_reg, sdaS3_reg} <= {sdaIn, sdaS1_reg, sdaS2_reg};
    end
  end

  always_ff @(posedge clk) begin
    strapS1_reg <= {modeStrap, stringStrap, boostFreqStrap, dimFreqStrap};
    strapS2_reg <= strapS1_reg;
  end

  wire sclRise  = sclS2_reg & ~sclS3_reg;
  wire sclFall  = ~sclS2_reg & sclS3_reg;
  wire busStart = sclS2_reg & sclS3_reg & sdaS3_reg & ~sdaS2_reg;
  wire busStop  = sclS2_reg & sclS3_reg & ~sdaS3_reg & sdaS2_reg;

  // Straps are caught once after they have settled past the synchroniser
  logic [2:0] settleCnt_reg;
  logic       strapDone_reg;
  logic [2:0] modeCode_reg;
  logic [3:0] stringRes_reg, boostFreqRes_reg, dimFreqRes_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      settleCnt_reg    <= 3'h0;
      strapDone_reg    <= 1'b0;
      modeCode_reg     <= 3'h4;
      stringRes_reg    <= 4'h0;
      boostFreqRes_reg <= 4'h0;
      dimFreqRes_reg   <= 4'h0;
    end else if (!strapDone_reg) begin
      settleCnt_reg <= settleCnt_reg + 3'h1;
      if (settleCnt_reg == STRAP_SETTLE_CYCLES) begin
        strapDone_reg <= 1'b1;
        {modeCode_reg, stringRes_reg, boostFreqRes_reg, dimFreqRes_reg}
          <= strapS2_reg;
      end
    end
  end

  // Mode codes 4..7 count as a missing or bad strap
  wire modeValid = strapDone_reg & ~modeCode_reg[2];
  wire dimMode   = modeValid & modeCode_reg[0];
  wire [6:0] targetAddr = (modeValid && modeCode_reg[1]) ?
                          ADDR_ALTERNATE : ADDR_PRIMARY;

  // Serial engine
  bli_i2c_e    state_reg;
  logic [3:0]  bitCnt_reg;
  logic [7:0]  rxByte_reg;
  logic [7:0]  regAddr_reg;
  logic [7:0]  hiByte_reg;
  logic [15:0] rdShift_reg;
  logic [15:0] wrData_reg;
  logic        wrStb_reg;
  logic        readDir_reg, dataIdx_reg, rdByte_reg, hostAck_reg;
  logic        sdaOe_reg;
  logic [TW-1:0] timeoutCnt_reg;
  logic [15:0] readWord;

  wire rxState  = (state_reg == ST_ADDR) || (state_reg == ST_REG) ||
                  (state_reg == ST_WDATA);
  wire cntState = rxState || (state_reg == ST_RDATA);
  wire byteFull = (bitCnt_reg == BITS_PER_BYTE);
  wire timeoutEvt = (state_reg != ST_IDLE) &&
                    (timeoutCnt_reg == TIMEOUT_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst || busStart || (sclFall && byteFull))
      bitCnt_reg <= 4'h0;
    else if (sclRise && cntState)
      bitCnt_reg <= bitCnt_reg + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst)
      rxByte_reg <= 8'h00;
    else if (sclRise && rxState)
      rxByte_reg <= {rxByte_reg[6:0], sdaS2_reg};
  end

  always_ff @(posedge clk) begin
    if (sys_rst || state_reg == ST_IDLE)
      timeoutCnt_reg <= '0;
    else
      timeoutCnt_reg <= timeoutCnt_reg + TW'(1);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg   <= ST_IDLE;
      sdaOe_reg   <= 1'b0;
      regAddr_reg <= 8'h00;
      hiByte_reg  <= 8'h00;
      rdShift_reg <= 16'h0000;
      wrData_reg  <= 16'h0000;
      wrStb_reg   <= 1'b0;
      readDir_reg <= 1'b0;
      dataIdx_reg <= 1'b0;
      rdByte_reg  <= 1'b0;
      hostAck_reg <= 1'b0;
    end else begin
      wrStb_reg <= 1'b0;
      if (busStop || timeoutEvt) begin
        state_reg <= ST_IDLE;
        sdaOe_reg <= 1'b0;
      end else if (busStart) begin
        state_reg <= ST_ADDR;
        sdaOe_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
          end
          ST_ADDR: begin
            if (sclFall && byteFull) begin
              if (rxByte_reg[7:1] == targetAddr) begin
                state_reg   <= ST_ACK_ADDR;
                sdaOe_reg   <= 1'b1;
                readDir_reg <= rxByte_reg[0];
              end else begin
                state_reg <= ST_IGNORE;
              end
            end
          end
          ST_ACK_ADDR: begin
            if (sclFall) begin
              if (readDir_reg) begin
                state_reg   <= ST_RDATA;
                rdShift_reg <= readWord;
                sdaOe_reg   <= ~readWord[15];
                rdByte_reg  <= 1'b0;
              end else begin
                state_reg <= ST_REG;
                sdaOe_reg <= 1'b0;
              end
            end
          end
          ST_REG: begin
            if (sclFall && byteFull) begin
              regAddr_reg <= rxByte_reg;
              state_reg   <= ST_ACK_REG;
              sdaOe_reg   <= 1'b1;
            end
          end
          ST_ACK_REG: begin
            if (sclFall) begin
              state_reg   <= ST_WDATA;
              sdaOe_reg   <= 1'b0;
              dataIdx_reg <= 1'b0;
            end
          end
          ST_WDATA: begin
            if (sclFall && byteFull) begin
              state_reg <= ST_ACK_WDATA;
              sdaOe_reg <= 1'b1;
              if (!dataIdx_reg) begin
                hiByte_reg <= rxByte_reg;
              end else begin
                wrStb_reg  <= 1'b1;
                wrData_reg <= {hiByte_reg, rxByte_reg};
              end
            end
          end
          ST_ACK_WDATA: begin
            if (sclFall) begin
              sdaOe_reg <= 1'b0;
              if (!dataIdx_reg) begin
                dataIdx_reg <= 1'b1;
                state_reg   <= ST_WDATA;
              end else begin
                state_reg <= ST_IGNORE;
              end
            end
          end
          ST_RDATA: begin
            if (sclFall) begin
              rdShift_reg <= {rdShift_reg[14:0], 1'b0};
              if (byteFull) begin
                sdaOe_reg <= 1'b0;
                state_reg <= ST_RD_ACK;
              end else begin
                sdaOe_reg <= ~rdShift_reg[14];
              end
            end
          end
          ST_RD_ACK: begin
            if (sclRise) begin
              hostAck_reg <= ~sdaS2_reg;
            end else if (sclFall) begin
              if (hostAck_reg && !rdByte_reg) begin
                rdByte_reg <= 1'b1;
                state_reg  <= ST_RDATA;
                sdaOe_reg  <= ~rdShift_reg[15];
              end else begin
                state_reg <= ST_IGNORE;
              end
            end
          end
          ST_IGNORE: begin
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Register file; writes land whatever the device state is
  logic [15:0] brightness_reg, sinkCurrent_reg, generalA_reg, generalB_reg;
  wire wrOk = wrStb_reg && isMapped(regAddr_reg);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      brightness_reg  <= RST_BRIGHTNESS;
      sinkCurrent_reg <= RST_SINK_CURRENT;
      generalA_reg    <= RST_GENERAL_A;
      generalB_reg    <= RST_GENERAL_B;
    end else if (wrOk) begin
      if (regAddr_reg == OFF_BRIGHTNESS)   brightness_reg  <= wrData_reg;
      if (regAddr_reg == OFF_SINK_CURRENT) sinkCurrent_reg <= wrData_reg;
      if (regAddr_reg == OFF_GENERAL_A)    generalA_reg    <= wrData_reg;
      if (regAddr_reg == OFF_GENERAL_B)    generalB_reg    <= wrData_reg;
    end
  end

  // Fault flags and alert enables, one row per group
  logic [FAULT_GROUPS-1:0][7:0]  flag_reg, alertEn_reg, faultEvt;
  logic [FAULT_GROUPS-1:0][15:0] flagWord, enWord;
  wire  [FAULT_GROUPS-1:0][7:0]  offFlags = {OFF_STRING_FLAGS,
                                   OFF_BOOST_FLAGS, OFF_SUPPLY_FLAGS};
  wire  [FAULT_GROUPS-1:0][7:0]  offEn = {OFF_STRING_EN, OFF_BOOST_EN,
                                   OFF_SUPPLY_EN};

  // The global slot holds an enable only and never latches a fault
  assign faultEvt[0] = {1'b0, faultIn.supply[TIMEOUT_FAULT_IDX] | timeoutEvt,
                        faultIn.supply[5:0]};
  assign faultEvt[1] = faultIn.boost;
  assign faultEvt[2] = faultIn.strng;

  genvar g, i;
  generate
    for (g = 0; g < FAULT_GROUPS; g++) begin : g_grp
      for (i = 0; i < FAULTS_PER_GROUP; i++) begin : g_bit
        wire clrHit = wrOk && (regAddr_reg == offFlags[g]) &&
                      wrData_reg[2*i] && wrData_reg[2*i+1];
        wire enHit  = wrOk && (regAddr_reg == offEn[g]);
        wire [1:0] enCode = wrData_reg[2*i+1:2*i];
        always_ff @(posedge clk) begin
          if (sys_rst)
            flag_reg[g][i] <= 1'b0;
          else if (faultEvt[g][i])
            flag_reg[g][i] <= 1'b1;
          else if (clrHit)
            flag_reg[g][i] <= 1'b0;
        end
        always_ff @(posedge clk) begin
          if (sys_rst)
            alertEn_reg[g][i] <= RST_ALERT_EN[i];
          else if (enHit && enCode == ALERT_DISABLE)
            alertEn_reg[g][i] <= 1'b0;
          else if (enHit && enCode == ALERT_ENABLE)
            alertEn_reg[g][i] <= 1'b1;
        end
        assign flagWord[g][2*i+1:2*i] = {1'b0, flag_reg[g][i]};
        assign enWord[g][2*i+1:2*i] = {alertEn_reg[g][i], 1'b0};
      end
    end
  endgenerate

  wire globalEn = alertEn_reg[0][GLOBAL_ALERT_IDX];
  wire alertNext = globalEn && |(flag_reg & alertEn_reg);

  logic alertOe_reg;
  always_ff @(posedge clk) begin
    if (sys_rst)
      alertOe_reg <= 1'b0;
    else
      alertOe_reg <= alertNext;
  end

  wire [15:0] strapWord = {dimFreqRes_reg, boostFreqRes_reg, stringRes_reg,
                           3'h0, dimMode};

  always_comb begin
    readWord = 16'h0000;
    if (isMapped(regAddr_reg)) begin
      case (regAddr_reg)
        OFF_BRIGHTNESS:   readWord = brightness_reg;
        OFF_SINK_CURRENT: readWord = sinkCurrent_reg;
        OFF_GENERAL_A:    readWord = generalA_reg;
        OFF_GENERAL_B:    readWord = generalB_reg;
        OFF_SUPPLY_EN:    readWord = enWord[0];
        OFF_BOOST_EN:     readWord = enWord[1];
        OFF_STRING_EN:    readWord = enWord[2];
        OFF_SUPPLY_FLAGS: readWord = flagWord[0];
        OFF_BOOST_FLAGS:  readWord = flagWord[1];
        OFF_STRING_FLAGS: readWord = flagWord[2];
        OFF_STATE_RD:     readWord = {8'h00, diagIn.liveStateField};
        OFF_IN_DUTY_RD:   readWord = diagIn.inputDuty;
        OFF_OUT_DUTY_RD:  readWord = diagIn.outputDutyField;
        OFF_SINK_DAC_RD:  readWord = {4'h0, diagIn.sinkDacField};
        OFF_BOOST_TGT_RD: readWord = {6'h00, diagIn.boostTargetField};
        OFF_STRAP_RD:     readWord = strapWord;
        default:          readWord = 16'h0000;
      endcase
    end
  end

  // Configuration outputs
  wire [1:0] srcSel = generalA_reg[GA_SRC_POS +: 2];
  wire [2:0] ditherRaw = generalA_reg[GA_DITHER_POS +: 3];
  bli_cfg_s cfgNext;
  assign cfgNext.brightnessWord = brightness_reg;
  assign cfgNext.sinkCurrent    = sinkCurrent_reg[11:0];
  assign cfgNext.spreadRange    = generalA_reg[GA_RANGE_POS +: 2];
  assign cfgNext.spreadRateSel  = generalA_reg[GA_RATE_POS +: 2];
  assign cfgNext.spreadPseudoEn = generalA_reg[GA_PSEUDO_POS];
  assign cfgNext.rampSel        = generalA_reg[GA_RAMP_POS +: 3];
  assign cfgNext.smoothRampEn   = generalA_reg[GA_SMOOTH_POS];
  // Codes above three saturate; the dimming path has three dither bits
  assign cfgNext.ditherBits = (ditherRaw > MAX_DITHER) ?
                              MAX_DITHER : ditherRaw;
  assign cfgNext.generalB   = generalB_reg;

  bli_cfg_s    cfgOut_reg;
  logic [15:0] effBrightness_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgOut_reg        <= '0;
      effBrightness_reg <= 16'h0000;
    end else begin
      cfgOut_reg <= cfgNext;
      // Reserved source codes keep the last brightness
      if (srcSel == SRC_PIN)
        effBrightness_reg <= diagIn.inputDuty;
      else if (srcSel == SRC_REG)
        effBrightness_reg <= brightness_reg;
    end
  end

  assign sdaOut        = 1'b0;
  assign sdaOe         = sdaOe_reg;
  assign alertOut      = 1'b0;
  assign alertOe       = alertOe_reg;
  assign cfgOut        = cfgOut_reg;
  assign effBrightness = effBrightness_reg;

  sequence s_addr_byte;
    state_reg == ST_ADDR && sclFall && byteFull;
  endsequence
  sequence s_read_turn;
    state_reg == ST_ACK_ADDR && sclFall && readDir_reg && !busStart &&
    !busStop && !timeoutEvt;
  endsequence

  property p_addr_ack;
    @(posedge clk) disable iff (sys_rst)
    s_addr_byte and (rxByte_reg[7:1] == targetAddr && !busStart &&
    !busStop && !timeoutEvt) |=> state_reg == ST_ACK_ADDR && sdaOe_reg;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("matching address not acknowledged");

  property p_default_addr;
    @(posedge clk) disable iff (sys_rst)
    !modeValid |-> targetAddr == ADDR_PRIMARY && !dimMode;
  endproperty
  a_default_addr: assert property (p_default_addr)
    else $error("bad strap did not give default address and mode");

  property p_read_msb;
    @(posedge clk) disable iff (sys_rst)
    s_read_turn |=> sdaOe_reg == ~$past(readWord[15]) &&
                    rdShift_reg == $past(readWord);
  endproperty
  a_read_msb: assert property (p_read_msb)
    else $error("read did not start with the high bit");

  property p_write_lands;
    @(posedge clk) disable iff (sys_rst)
    wrStb_reg && regAddr_reg == OFF_BRIGHTNESS |=>
      brightness_reg == $past(wrData_reg) ##2
      effBrightness_reg == brightness_reg || srcSel != SRC_REG;
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("brightness write did not take effect");

  property p_half_clear;
    @(posedge clk) disable iff (sys_rst)
    wrOk && regAddr_reg == OFF_BOOST_FLAGS && wrData_reg[1:0] != 2'b11 &&
    flag_reg[1][0] |=> flag_reg[1][0];
  endproperty
  a_half_clear: assert property (p_half_clear)
    else $error("flag cleared without both bits set");

  property p_set_wins;
    @(posedge clk) disable iff (sys_rst)
    faultEvt[1][0] |=> flag_reg[1][0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("fault event lost");

  property p_en_disable;
    @(posedge clk) disable iff (sys_rst)
    wrOk && regAddr_reg == OFF_BOOST_EN && wrData_reg[1:0] == ALERT_DISABLE
    |=> !alertEn_reg[1][0] && enWord[1][1:0] == 2'b00;
  endproperty
  a_en_disable: assert property (p_en_disable)
    else $error("alert enable not disabled by 01");

  property p_global_block;
    @(posedge clk) disable iff (sys_rst)
    !globalEn |=> !alertOe_reg;
  endproperty
  a_global_block: assert property (p_global_block)
    else $error("alert raised with global enable off");

  property p_alert_raise;
    @(posedge clk) disable iff (sys_rst)
    globalEn && flag_reg[1][0] && alertEn_reg[1][0] |=> alertOe_reg;
  endproperty
  a_alert_raise: assert property (p_alert_raise)
    else $error("enabled fault did not raise alert");

  property p_timeout;
    @(posedge clk) disable iff (sys_rst)
    timeoutEvt |=> state_reg == ST_IDLE && flag_reg[0][TIMEOUT_FAULT_IDX];
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("bus timeout not flagged");

  property p_dither_cap;
    @(posedge clk) disable iff (sys_rst)
    ditherRaw > MAX_DITHER |=> cfgOut_reg.ditherBits == MAX_DITHER;
  endproperty
  a_dither_cap: assert property (p_dither_cap)
    else $error("dither above three bits");
endmodule // bli_regbank
`default_nettype wire

// file: bli_host.sv
`default_nettype none
module bli_host (
  input  wire logic clk,
  input  wire logic sdaOe,
  output wire logic sclIn,
  output wire logic sdaIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl = 1'b1;
  logic sda = 1'b1;
  assign sclIn = scl;
  // Pull-up: a released line reads high
  assign sdaIn = sda & ~sdaOe;
  // SDA moves mid-low so it never races an SCL edge
  task automatic bt(input logic b, output logic r);
    scl <= 1'b0;
    repeat (4) @(posedge clk);
    sda <= b;
    repeat (4) @(posedge clk);
    scl <= 1'b1;
    repeat (8) @(posedge clk);
    r = sdaIn;
  endtask
  task automatic start();
    logic r;
    bt(1'b1, r);
    sda <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic stop();
    logic r;
    bt(1'b0, r);
    sda <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic xb(input logic [7:0] d, input logic hAck,
                    output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(d[i], r);
      q[i] = r;
    end
    bt(~hAck, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] g,
                    input logic [15:0] d, output logic ok);
    logic [7:0] q;
    logic [3:0] k;
    start();
    xb({a, 1'b0}, 1'b0, q, k[0]);
    xb(g, 1'b0, q, k[1]);
    xb(d[15:8], 1'b0, q, k[2]);
    xb(d[7:0], 1'b0, q, k[3]);
    stop();
    ok = &k;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] g,
                    output logic [15:0] d, output logic ok);
    logic [2:0] k;
    logic j;
    start();
    xb({a, 1'b0}, 1'b0, d[7:0], k[0]);
    xb(g, 1'b0, d[7:0], k[1]);
    start();
    xb({a, 1'b1}, 1'b0, d[7:0], k[2]);
    xb(8'hff, 1'b1, d[15:8], j);
    xb(8'hff, 1'b0, d[7:0], j);
    stop();
    ok = &k;
  endtask
endmodule // bli_host
`default_nettype wire

// file: bli_regbank_bench.sv
`default_nettype none
module bli_regbank_bench
  import bli_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sclIn, sdaIn, sdaOe, sdaOut, alertOe, alertOut, ok;
  logic [2:0] modeStrap = 3'h6;
  logic [15:0] d, effBrightness;
  logic [7:0] q;
  bli_faults_s faultIn = '0;
  bli_diag_s diagIn = '{8'h5a, 16'hbeef, 16'hc3d2, 12'habc, 10'h155};
  bli_cfg_s cfgOut;
  logic [15:0] dx [5] = '{16'h005a, 16'hbeef, 16'hc3d2, 16'h0abc, 16'h0155};
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  bli_regbank #(.TIMEOUT_CYCLES(2000)) DUT (.clk(clk), .sys_rst(sys_rst),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .modeStrap(modeStrap), .stringStrap(4'h3), .boostFreqStrap(4'h5),
    .dimFreqStrap(4'h9), .faultIn(faultIn), .diagIn(diagIn),
    .cfgOut(cfgOut), .effBrightness(effBrightness), .alertOut(alertOut),
    .alertOe(alertOe));
  bli_host host (.clk(clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      $display("mismatch at %0t: run too long", $time);
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    host.rd(ADDR_PRIMARY, a, d, ok);
    chk(d, exp);
    chk(16'(ok), 16'h0001);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    host.wr(ADDR_PRIMARY, a, v, ok);
    chk(16'(ok), 16'h0001);
  endtask
  task automatic pulse();
    faultIn <= 24'h000100;
    @(posedge clk);
    faultIn <= '0;
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk);
    rdc(OFF_SINK_CURRENT, RST_SINK_CURRENT);
    rdc(OFF_GENERAL_A, RST_GENERAL_A);
    rdc(OFF_BOOST_EN, 16'haaaa);
    $display("test reset values done");
    wr(OFF_BRIGHTNESS, 16'h1234);
    rdc(OFF_BRIGHTNESS, 16'h1234);
    chk(cfgOut.brightnessWord, 16'h1234);
    wr(OFF_SINK_CURRENT, 16'hf123);
    chk(16'(cfgOut.sinkCurrent), 16'h0123);
    wr(OFF_GENERAL_B, 16'h5a5a);
    rdc(OFF_GENERAL_B, 16'h5a5a);
    chk(cfgOut.generalB, 16'h5a5a);
    wr(OFF_GENERAL_A, 16'h7a9e);
    chk(effBrightness, 16'h1234);
    chk(16'(cfgOut.ditherBits), 16'h0003);
    chk(16'({cfgOut.spreadRange, cfgOut.spreadRateSel}), 16'h000b);
    chk(16'({cfgOut.spreadPseudoEn, cfgOut.rampSel}), 16'h000c);
    chk(16'(cfgOut.smoothRampEn), 16'h0001);
    rdc(OFF_GENERAL_A, 16'h7a9e);
    wr(OFF_GENERAL_A, 16'h789e);
    chk(effBrightness, 16'hbeef);
    $display("test config done");
    for (int i = 0; i < 5; i++)
      rdc(8'(8'h14 + 2 * i), dx[i]);
    rdc(OFF_STRAP_RD, 16'h9530);
    host.rd(ADDR_ALTERNATE, OFF_BRIGHTNESS, d, ok);
    chk(16'(ok), 16'h0000);
    rdc(8'h20, 16'h0000);
    rdc(8'h01, 16'h0000);
    $display("test readouts done");
    pulse();
    chk(16'(alertOe), 16'h0001);
    rdc(OFF_BOOST_FLAGS, 16'h0001);
    wr(OFF_BOOST_FLAGS, 16'h0001);
    rdc(OFF_BOOST_FLAGS, 16'h0001);
    wr(OFF_BOOST_FLAGS, 16'h0003);
    rdc(OFF_BOOST_FLAGS, 16'h0000);
    chk(16'(alertOe), 16'h0000);
    wr(OFF_BOOST_EN, 16'h0001);
    rdc(OFF_BOOST_EN, 16'haaa8);
    pulse();
    chk(16'(alertOe), 16'h0000);
    wr(OFF_BOOST_EN, 16'h0003);
    chk(16'(alertOe), 16'h0001);
    wr(OFF_SUPPLY_EN, 16'h4000);
    chk(16'(alertOe), 16'h0000);
    chk(16'({sdaOut, alertOut}), 16'h0000);
    $display("test alerts done");
    host.start();
    host.xb({ADDR_PRIMARY, 1'b0}, 1'b0, q, ok);
    repeat (2100) @(posedge clk);
    host.stop();
    rdc(OFF_SUPPLY_FLAGS, 16'h1000);
    chk(16'(alertOe), 16'h0000);
    $display("test bus timeout done");
    // Straps are only caught after reset, so change them while in reset
    sys_rst <= 1'b1;
    modeStrap <= 3'h3;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (20) @(posedge clk);
    chk(cfgOut.brightnessWord, RST_BRIGHTNESS);
    chk(16'(alertOe), 16'h0000);
    host.rd(ADDR_ALTERNATE, OFF_STRAP_RD, d, ok);
    chk(d, 16'h9531);
    chk(16'(ok), 16'h0001);
    $display("test strap address done");
    end_sim();
  end
endmodule // bli_regbank_bench
`default_nettype wire
